/* File: hw/hcms_sequencer.sv */
// Mode and start-up sequencer for a harvesting boost charger, APB slave.
// Assumes all comparator flags are synchronous to CLOCK and debounced.
module hcms_sequencer import hcms_pkg::*; #(
    parameter int INHIBIT_CYC = CYC_INHIBIT,
    parameter int SAMPLE_CYC  = CYC_SAMPLE,
    parameter int HOTPLUG_CYC = CYC_HOTPLUG
) (
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Shutdown pin, high means disabled
    input  wire logic        ENABLE_N,
    // Comparator flags
    input  wire logic        STOR_ABOVE_CHGEN,
    input  wire logic        VIN_ABOVE_CS,
    input  wire logic        PIN_SUFFICIENT,
    input  wire logic        VIN_PRESENT,
    input  wire logic        VIN_ABOVE_REF,
    input  wire logic        STOR_ABOVE_UV_HYST,
    input  wire logic        STOR_BELOW_UV,
    input  wire logic        STOR_ABOVE_OV,
    input  wire logic        STOR_BELOW_OV_HYST,
    input  wire logic        STOR_NEAR_ZERO,
    input  wire logic        SEC_NEAR_ZERO,
    input  wire logic        SEC_ATTACH,
    input  wire logic        STOR_DROOP,
    input  wire logic        TEMP_HOT,
    input  wire logic        TEMP_COOL,
    // Power stage controls
    output logic             COLDSTART_EN,
    output logic             BOOST_EN,
    output logic             SWITCH_CLOSED,
    output logic             DIV_INIT_PULSE,
    output logic             SAMPLE_PULSE,
    output logic             BURST_START,
    output logic      [1:0]  PEAK_LEVEL
);
    // ==========================================================
    // Elaboration checks
    if (INHIBIT_CYC < 1 || SAMPLE_CYC <= INHIBIT_CYC || HOTPLUG_CYC < 1) begin : g_bad_times
        $error("hcms_sequencer: interval counts out of order");
    end
    if (SAMPLE_CYC >= (1 << TMR_W) || HOTPLUG_CYC >= (1 << TMR_W)) begin : g_bad_width
        $error("hcms_sequencer: interval exceeds timer width");
    end

    localparam logic [TMR_W-1:0] INH_END = TMR_W'(INHIBIT_CYC - 1);
    localparam logic [TMR_W-1:0] SMP_END = TMR_W'(SAMPLE_CYC - 1);
    localparam logic [TMR_W-1:0] HP_END  = TMR_W'(HOTPLUG_CYC - 1);
    // Settle ends one sample period after the pulse, so the inhibit counts inside it
    localparam logic [TMR_W-1:0] SET_END = TMR_W'(SAMPLE_CYC - INHIBIT_CYC - 1);

    // ==========================================================
    // Internal state
    hcms_state_t state;
    hcms_state_t next_state;
    logic        ov_stop;
    logic        hp_block;
    logic        uv_held;
    logic        droop_d;
    logic [2:0]  ctrl;
    logic        period_end;
    logic        charging;

    hcms_tmr_if #(.W(TMR_W)) tmr_bus ();

    hcms_interval_timer #(.W(TMR_W)) u_timer (
        .clk (CLOCK),
        .rst (RST),
        .bus (tmr_bus.tmr)
    );

    // ==========================================================
    // Mode selection
    always_comb begin
        next_state = state;
        case (state)
            S_COLD: begin
                if (STOR_ABOVE_CHGEN) begin
                    next_state = S_INIT;
                end else if (SEC_ATTACH && STOR_NEAR_ZERO && SEC_NEAR_ZERO) begin
                    next_state = S_HPON;
                end
            end
            S_HPON: begin
                if (tmr_bus.elapsed >= HP_END) begin
                    next_state = S_INIT;
                end
            end
            S_INIT: next_state = S_INHIBIT;
            S_INHIBIT: begin
                if (tmr_bus.elapsed >= INH_END) begin
                    next_state = S_SETTLE;
                end
            end
            S_SETTLE: begin
                if (tmr_bus.elapsed >= SET_END) begin
                    next_state = S_RUN;
                end
            end
            S_RUN: begin
                if (TEMP_HOT) begin
                    next_state = S_THERM;
                end
            end
            S_THERM: begin
                // Resume only at the lower threshold, so no chatter
                if (TEMP_COOL && !TEMP_HOT) begin
                    next_state = S_RUN;
                end
            end
            S_SHIP: begin
                if (!ENABLE_N) begin
                    next_state = S_RUN;
                end
            end
            default: next_state = S_COLD;
        endcase
        // Cold start ignores the pin; hot-plug charges the output itself
        if (state != S_COLD && state != S_HPON) begin
            if (!STOR_ABOVE_CHGEN) begin
                next_state = S_COLD;
            end else if (ENABLE_N) begin
                next_state = S_SHIP;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state <= S_COLD;
        end else begin
            state <= next_state;
        end
    end

    // One shared timer, restarted on every mode change and each period
    assign period_end      = (state == S_RUN) && (tmr_bus.elapsed >= SMP_END);
    assign tmr_bus.restart = (next_state != state) || period_end;
    assign charging        = (state == S_RUN) || (state == S_SETTLE);

    // ==========================================================
    // Protection flags; a set in the same cycle as its clear wins
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ov_stop <= 1'b0;
        end else if (STOR_ABOVE_OV) begin
            ov_stop <= 1'b1;
        end else if (STOR_BELOW_OV_HYST) begin
            ov_stop <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            hp_block <= 1'b0;
        end else if (SEC_ATTACH && !STOR_NEAR_ZERO) begin
            hp_block <= 1'b1;
        end else if (VIN_PRESENT) begin
            hp_block <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            uv_held <= 1'b0;
        end else if (state == S_INIT) begin
            uv_held <= 1'b1;
        end else if (STOR_BELOW_UV) begin
            uv_held <= 1'b0;
        end
    end

    // ==========================================================
    // Storage switch
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            SWITCH_CLOSED <= 1'b0;
        end else if (state == S_HPON) begin
            SWITCH_CLOSED <= 1'b1;
        end else if (STOR_BELOW_UV) begin
            SWITCH_CLOSED <= 1'b0;
        end else begin
            case (state)
                S_SETTLE: SWITCH_CLOSED <= (next_state == S_RUN) && uv_held && !hp_block;
                S_RUN, S_THERM: begin
                    if (STOR_ABOVE_UV_HYST && !hp_block) begin
                        SWITCH_CLOSED <= 1'b1;
                    end
                end
                default: SWITCH_CLOSED <= 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Converter controls
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            COLDSTART_EN <= 1'b0;
            BOOST_EN     <= 1'b0;
        end else begin
            COLDSTART_EN <= (state == S_COLD) && !STOR_ABOVE_CHGEN
                            && VIN_ABOVE_CS && PIN_SUFFICIENT;
            BOOST_EN     <= charging && !ov_stop && !STOR_ABOVE_OV
                            && VIN_ABOVE_REF;
        end
    end

    // Divider init and sample strobes
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            DIV_INIT_PULSE <= 1'b0;
            SAMPLE_PULSE   <= 1'b0;
        end else begin
            DIV_INIT_PULSE <= (state == S_INIT);
            SAMPLE_PULSE   <= ((state == S_SETTLE) && (next_state == S_RUN))
                              || period_end;
        end
    end

    // ==========================================================
    // Burst restart and peak-current dither
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            droop_d     <= 1'b0;
            BURST_START <= 1'b0;
            PEAK_LEVEL  <= 2'h0;
        end else begin
            droop_d     <= STOR_DROOP;
            BURST_START <= BOOST_EN && STOR_DROOP && !droop_d;
            if (!ctrl[CTRL_DITHER]) begin
                PEAK_LEVEL <= 2'h0;
            end else if (BOOST_EN && STOR_DROOP && !droop_d) begin
                PEAK_LEVEL <= (PEAK_LEVEL >= ctrl[1:0] || PEAK_LEVEL >= PEAK_LEVELS_MAX)
                              ? 2'h0 : PEAK_LEVEL + 2'h1;
            end
        end
    end

    // ==========================================================
    // APB slave: one wait-free access phase, answer registered in setup
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= PSEL && !PENABLE
                       && (PADDR != ADDR_CTRL) && (PADDR != ADDR_STATUS);
            if (PSEL && !PENABLE && !PWRITE) begin
                case (PADDR)
                    ADDR_CTRL:   PRDATA <= {29'h0, ctrl};
                    ADDR_STATUS: PRDATA <= {17'h0, hp_block, ov_stop, PEAK_LEVEL,
                                            SWITCH_CLOSED, BOOST_EN, COLDSTART_EN,
                                            state};
                    default:     PRDATA <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ctrl <= CTRL_RESET;
        end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == ADDR_CTRL) begin
            ctrl <= PWDATA[2:0];
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence s_init_pulse;
        state == S_INIT ##1 DIV_INIT_PULSE && state == S_INHIBIT;
    endsequence

    a_ship_shutdown: assert property (
        state == S_SHIP |=> !BOOST_EN && !SWITCH_CLOSED)
        else $error("ship mode left boost or switch on");
    a_cold_ignores_pin: assert property (
        state == S_COLD |=> state != S_SHIP)
        else $error("cold start obeyed shutdown pin");
    a_cold_converter: assert property (
        state == S_COLD && !STOR_ABOVE_CHGEN && VIN_ABOVE_CS && PIN_SUFFICIENT
        |=> COLDSTART_EN)
        else $error("cold-start converter not enabled");
    a_init_sequence: assert property (
        state == S_COLD && STOR_ABOVE_CHGEN |=> s_init_pulse)
        else $error("init pulse missing after cold start");
    a_ov_stop: assert property (
        STOR_ABOVE_OV |=> !BOOST_EN)
        else $error("boost ran at overvoltage");
    a_uv_opens: assert property (
        STOR_BELOW_UV && state != S_HPON |=> !SWITCH_CLOSED)
        else $error("switch closed below undervoltage");
    a_ref_gate: assert property (
        BOOST_EN |-> $past(VIN_ABOVE_REF) && $past(charging))
        else $error("charge transfer without input above reference");
    a_hot_hold: assert property (
        state == S_THERM && !TEMP_COOL && STOR_ABOVE_CHGEN && !ENABLE_N
        |=> state == S_THERM)
        else $error("thermal shutdown left before cooling");
    a_hotplug_on: assert property (
        state == S_HPON |=> SWITCH_CLOSED)
        else $error("hot-plug switch not closed");
endmodule : hcms_sequencer

/* File: hw/hcms_pkg.sv */
// Constants shared by the charger mode sequencer and its interval timer.
// Assumes a single 40 MHz clock and comparator flags already synchronous.
package hcms_pkg;

    // ==========================================================
    // Clock and interval timing
    localparam int CLK_MHZ        = 40;
    localparam int T_INHIBIT_US   = 32000;
    localparam int T_SAMPLE_US    = 64000;
    localparam int T_HOTPLUG_US   = 45000;
    localparam int CYC_INHIBIT    = T_INHIBIT_US * CLK_MHZ;
    localparam int CYC_SAMPLE     = T_SAMPLE_US * CLK_MHZ;
    localparam int CYC_HOTPLUG    = T_HOTPLUG_US * CLK_MHZ;
    localparam int TMR_W          = 22;

    // ==========================================================
    // Register map (byte addresses) and reset values
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam int          CTRL_LVL_LSB = 0;
    localparam int          CTRL_DITHER  = 2;
    localparam logic [2:0]  CTRL_RESET  = 3'h6;
    localparam logic [1:0]  PEAK_LEVELS_MAX = 2'h2;

    // ==========================================================
    // Operating modes, one-hot
    typedef enum logic [7:0] {
        S_SHIP    = 8'h01,
        S_COLD    = 8'h02,
        S_HPON    = 8'h04,
        S_INIT    = 8'h08,
        S_INHIBIT = 8'h10,
        S_SETTLE  = 8'h20,
        S_RUN     = 8'h40,
        S_THERM   = 8'h80
    } hcms_state_t;

endpackage : hcms_pkg

/* File: hw/hcms_tmr_if.sv */
// Carrier between the sequencer and its interval timer.
// Assumes both ends share the sequencer clock.
interface hcms_tmr_if #(parameter int W = 22);
    logic         restart;
    logic [W-1:0] elapsed;
    modport ctl (output restart, input elapsed);
    modport tmr (input restart, output elapsed);
endinterface : hcms_tmr_if

/* File: hw/hcms_interval_timer.sv */
// Saturating cycle counter used for every sequencer interval.
// Assumes restart is a level sampled each clock edge.
module hcms_interval_timer import hcms_pkg::*; #(
    parameter int W = TMR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Timer carrier
    hcms_tmr_if.tmr  bus
);
    // ==========================================================
    // Counter; saturates so a long wait never wraps into a false match
    always_ff @(posedge clk) begin
        if (rst || bus.restart) begin
            bus.elapsed <= '0;
        end else if (bus.elapsed != {W{1'b1}}) begin
            bus.elapsed <= bus.elapsed + 1'b1;
        end
    end
endmodule : hcms_interval_timer

/* File: verif/hcms_partner.sv */
// Harvester source and storage element model that drives the comparator flags.
// Assumes the bench sets node levels in mV and temperature in C; flags are registered.
module hcms_partner #(
    parameter int CHGEN_MV = 1800,
    parameter int UV_MV    = 1950,
    parameter int UVH_MV   = 2050,
    parameter int OV_MV    = 4200,
    parameter int OVH_MV   = 4100,
    parameter int CS_MV    = 600,
    parameter int ZERO_MV  = 100
) (
    // Clock and reset
    input  wire logic   CLOCK,
    input  wire logic   RST,
    // Levels chosen by the bench
    input  int          stor_mv,
    input  int          sec_mv,
    input  int          vin_mv,
    input  int          ref_mv,
    input  int          temp_c,
    input  wire logic   attach,
    // Flags, storage-above-enable at the top down to cool at bit 0
    output logic [14:0] flags
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Flag generation
    logic       attach_q;
    logic [2:0] ph;

    // Droop repeats every 6 cycles whatever the charger does: the load sits behind
    // its own isolating switch and never rests
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            flags    <= 15'h0000;
            attach_q <= 1'b0;
            ph       <= 3'h0;
        end else begin
            attach_q <= attach;
            ph       <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
            flags    <= {stor_mv >= CHGEN_MV, vin_mv >= CS_MV, vin_mv >= CS_MV,
                         vin_mv > ZERO_MV, vin_mv > ref_mv, stor_mv >= UVH_MV,
                         stor_mv < UV_MV, stor_mv >= OV_MV, stor_mv < OVH_MV,
                         stor_mv < ZERO_MV, sec_mv < ZERO_MV, attach & ~attach_q,
                         ph < 3'h2, temp_c > 125, temp_c < 120};
        end
    end
endmodule : hcms_partner

/* File: verif/testbench.sv */
// Self-checking bench for the charger mode sequencer with shortened intervals.
// Assumes the partner model supplies every comparator flag.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import hcms_pkg::*;
    // ==========================================================
    // Signals
    localparam int INH_C = 8;
    localparam int SMP_C = 16;
    localparam int HP_C  = 12;
    logic        CLOCK, RST, PSEL, PENABLE, PWRITE, ENABLE_N, attach, er, dq;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic        PREADY, PSLVERR, COLDSTART_EN, BOOST_EN, SWITCH_CLOSED;
    logic        DIV_INIT_PULSE, SAMPLE_PULSE, BURST_START;
    logic [1:0]  PEAK_LEVEL, cap;
    logic [14:0] fl;
    logic [2:0]  cv, rv, mask;
    int          stor, sec, vin, vref, temp, fails, n_checks, n, fb, k, nb, nd;

    hcms_partner partner (.CLOCK(CLOCK), .RST(RST), .stor_mv(stor), .sec_mv(sec),
        .vin_mv(vin), .ref_mv(vref), .temp_c(temp), .attach(attach), .flags(fl));

    hcms_sequencer #(.INHIBIT_CYC(INH_C), .SAMPLE_CYC(SMP_C), .HOTPLUG_CYC(HP_C)) dut (
        .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .ENABLE_N(ENABLE_N), .STOR_ABOVE_CHGEN(fl[14]),
        .VIN_ABOVE_CS(fl[13]), .PIN_SUFFICIENT(fl[12]), .VIN_PRESENT(fl[11]),
        .VIN_ABOVE_REF(fl[10]), .STOR_ABOVE_UV_HYST(fl[9]), .STOR_BELOW_UV(fl[8]),
        .STOR_ABOVE_OV(fl[7]), .STOR_BELOW_OV_HYST(fl[6]), .STOR_NEAR_ZERO(fl[5]),
        .SEC_NEAR_ZERO(fl[4]), .SEC_ATTACH(fl[3]), .STOR_DROOP(fl[2]), .TEMP_HOT(fl[1]),
        .TEMP_COOL(fl[0]), .COLDSTART_EN(COLDSTART_EN), .BOOST_EN(BOOST_EN),
        .SWITCH_CLOSED(SWITCH_CLOSED), .DIV_INIT_PULSE(DIV_INIT_PULSE),
        .SAMPLE_PULSE(SAMPLE_PULSE), .BURST_START(BURST_START), .PEAK_LEVEL(PEAK_LEVEL));

    // ==========================================================
    // Helpers
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: got %h want %h", $time, m, seen, exp);
        end
    endtask : chk

    task tick(input int c);
        repeat (c) @(posedge CLOCK);
    endtask : tick

    task timeout;
        fails++;
        $display("[FAIL] %0t wait ran out", $time);
        print_verdict();
    endtask : timeout

    // Request held until PREADY is sampled high; no latency assumed
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int c;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        c = 0;
        do begin
            @(posedge CLOCK);
            c++;
        end while (PREADY !== 1'b1 && c < 50);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1) timeout();
    endtask : apb

    // Counts edges until the chosen output is seen high; notes first edge with boost on
    task wait_hi(input int sel);
        logic s;
        n = 0;
        fb = 0;
        do begin
            @(posedge CLOCK);
            n++;
            if (BOOST_EN === 1'b1 && fb == 0) fb = n;
            case (sel)
                0: s = DIV_INIT_PULSE;
                1: s = SAMPLE_PULSE;
                default: s = SWITCH_CLOSED;
            endcase
        end while (s !== 1'b1 && n < 400);
        if (s !== 1'b1) timeout();
    endtask : wait_hi

    task do_reset;
        RST <= 1'b1;
        tick(8);
        RST <= 1'b0;
        tick(2);
    endtask : do_reset

    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    initial begin
        repeat (100000) @(posedge CLOCK);
        timeout();
    end

    // ==========================================================
    // Scenarios
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, attach} <= '0;
        ENABLE_N <= 1'b0;
        stor <= 0;
        sec <= 0;
        vin <= 0;
        vref <= 500;
        temp <= 25;
        fails = 0;
        n_checks = 0;
        rv = 3'($urandom(32'h632E));
        do_reset();
        chk({COLDSTART_EN, BOOST_EN, SWITCH_CLOSED, SAMPLE_PULSE, PEAK_LEVEL}, 0, "reset");
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, {29'h0, CTRL_RESET}, "ctrl reset");
        apb(1'b1, ADDR_STATUS, 32'hFFFF);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h2, "status reset");
        apb(1'b0, 8'h08, 32'h0);
        chk(er, 1, "unmapped error");
        chk(rd, 0, "unmapped read");
        // Hot-plug from empty nodes
        attach <= 1'b1;
        tick(1);
        attach <= 1'b0;
        wait_hi(2);
        stor <= 2500;
        sec <= 2500;
        vin <= 1000;
        k = 1;
        while (k < 40) begin
            @(posedge CLOCK);
            if (SWITCH_CLOSED !== 1'b1) break;
            k++;
        end
        chk(k, HP_C, "switch on time");
        // The pulse rises with the switch opening and stands one cycle only
        chk(DIV_INIT_PULSE, 1, "init pulse");
        wait_hi(1);
        chk(fb >= INH_C && n == SMP_C, 1, "inhibit");
        tick(2);
        chk(SWITCH_CLOSED, 1, "switch recloses");
        wait_hi(1);
        // Two edges of the period went to the switch check
        chk(n + 2, SMP_C, "sample period");
        for (int i = 0; i < 6; i++) begin
            vin <= 200 + $urandom_range(0, 700);
            vref <= 250 + 100 * i;
            tick(4);
            chk(BOOST_EN, vin > vref, "boost vs ref");
        end
        vin <= 1000;
        vref <= 500;
        for (int i = 0; i < 8; i++) begin
            cv = 3'(i) ^ rv;
            apb(1'b1, ADDR_CTRL, {29'h0, cv});
            apb(1'b0, ADDR_CTRL, 32'h0);
            chk(rd, {29'h0, cv}, "ctrl rw");
            tick(12);
            mask = 3'h0;
            nb = 0;
            nd = 0;
            // Seed with the live level so a droop already high is no false edge
            dq = fl[2];
            repeat (48) begin
                @(posedge CLOCK);
                mask[PEAK_LEVEL] = 1'b1;
                nb += BURST_START;
                nd += fl[2] & ~dq;
                dq = fl[2];
            end
            cap = (cv[1:0] > 2'h2) ? 2'h2 : cv[1:0];
            chk(mask, cv[2] ? (3'h7 >> (2 - cap)) : 3'h1, "peak levels");
            chk(nb, nd, "bursts");
        end
        stor <= 4300;
        tick(4);
        chk(BOOST_EN, 0, "ov stop");
        stor <= 4150;
        tick(4);
        chk(BOOST_EN, 0, "ov hysteresis");
        stor <= 4000;
        tick(4);
        chk(BOOST_EN, 1, "ov restart");
        temp <= 130;
        tick(4);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({BOOST_EN, rd[7:0]}, 9'h080, "thermal stop");
        temp <= 122;
        stor <= 1900;
        tick(4);
        chk({BOOST_EN, SWITCH_CLOSED}, 0, "thermal uv");
        stor <= 2100;
        tick(4);
        chk(SWITCH_CLOSED, 1, "uv close");
        stor <= 2000;
        tick(4);
        chk(SWITCH_CLOSED, 1, "uv hold");
        temp <= 100;
        tick(4);
        chk(BOOST_EN, 1, "thermal resume");
        ENABLE_N <= 1'b1;
        tick(4);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({BOOST_EN, SWITCH_CLOSED, rd[7:0]}, 10'h001, "ship");
        ENABLE_N <= 1'b0;
        stor <= 1000;
        tick(4);
        chk({COLDSTART_EN, BOOST_EN}, 2'b10, "fallback");
        ENABLE_N <= 1'b1;
        tick(4);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({COLDSTART_EN, rd[7:0]}, 9'h102, "cold ignores pin");
        ENABLE_N <= 1'b0;
        vin <= 300;
        tick(4);
        chk(COLDSTART_EN, 0, "no input");
        // Leaving cold start on the output's own rise
        stor <= 2500;
        vin <= 1000;
        wait_hi(0);
        chk(n, 4, "cold exit pulse");
        wait_hi(1);
        chk(fb >= INH_C && n == SMP_C, 1, "cold exit sample");
        // Hot-plug onto a charged output after a reset in mid-run
        stor <= 500;
        sec <= 0;
        vin <= 0;
        do_reset();
        attach <= 1'b1;
        tick(1);
        attach <= 1'b0;
        tick(15);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({SWITCH_CLOSED, rd[14]}, 2'b01, "hot-plug block");
        vin <= 1000;
        tick(4);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[14], 0, "block released");
        print_verdict();
    end
endmodule : testbench
